// *** core/ohc_cfg.svh ***
// Constants of the operating hours counter: offsets, field positions, resets, limits, timing.
// Assumes inclusion by bare name from the counter and its bench.
`ifndef OHC_CFG_SVH
`define OHC_CFG_SVH

// Register byte offsets
`define OHC_OFS_CTRL      8'h00
`define OHC_OFS_INTERVAL  8'h04
`define OHC_OFS_OFFSET    8'h08
`define OHC_OFS_STATUS    8'h0C
`define OHC_OFS_TTG       8'h10
`define OHC_OFS_RUNH      8'h14

// Control register fields
`define OHC_CTRL_MODE_BIT    0
`define OHC_CTRL_SRC_BIT     1
`define OHC_CTRL_RUN_BIT     2
`define OHC_CTRL_BLK_LSB     8
`define OHC_CTRL_BLK_MSB     15

// Hours and minutes fields of interval and offset writes
`define OHC_HM_HOUR_LSB      0
`define OHC_HM_HOUR_MSB      16
`define OHC_HM_MIN_LSB       24
`define OHC_HM_MIN_MSB       29

// Status register fields
`define OHC_STAT_ALARM_BIT   0
`define OHC_STAT_MON_BIT     1
`define OHC_STAT_SEEN_BIT    2

// Reset values
`define OHC_RST_MODE         1'h0
`define OHC_RST_SRC          1'h0
`define OHC_RST_RUN          1'h1
`define OHC_RST_BLK          8'h00

// Limits
`define OHC_MIN_PER_HOUR     23'h00003C
`define OHC_MIN_MAX          6'h3B
`define OHC_INT_HOUR_MAX     17'h0270F
`define OHC_RUN_HOUR_MAX     17'h1869F
`define OHC_RUN_MAX_MIN      23'h5B8D44
`define OHC_INT_MAX_MIN      20'h927BF

// Timing: one minute of on-time in ns, clock period in ns
`define OHC_MINUTE_NS        64'h0000000DF8475800
`define OHC_CLK_NS           64'h000000000000000A

`endif

// *** core/ohc_pkg.sv ***
// Types shared by the operating hours counter files.
// Assumes the constants header sits beside it.
package ohc_pkg;
  // Alarm clear mode
  typedef enum logic {
    OHC_CLR_R    = 1'b0,  // Only the reset inputs clear
    OHC_CLR_R_EN = 1'b1   // Monitor low clears as well
  } ohc_clr_mode_t;

  typedef logic [22:0] ohc_run_min_t;  // Run time in minutes
  typedef logic [19:0] ohc_int_min_t;  // Interval or time-to-go in minutes
endpackage

// *** core/ohc_sync.sv ***
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous level input and one clock.
module ohc_sync (
  input  wire logic clock,   // System clock
  input  wire logic rst,     // Synchronous reset, high
  input  wire logic din,     // Asynchronous level
  output logic      dout     // Filtered level
);
  logic s1_r;  // First stage, read only by the second
  logic s2_r;  // Second stage
  logic s3_r;  // Third stage

  // Shift chain
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_r <= 1'h0;
      s2_r <= 1'h0;
      s3_r <= 1'h0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Output follows once second and third agree
  always_ff @(posedge clock) begin
    if (rst) begin
      dout <= 1'h0;
    end else if (s2_r == s3_r) begin
      dout <= s3_r;
    end
  end
endmodule

// *** core/ohc_nvstore.sv ***
// Retentive store of interval, time-to-go and run time.
// Assumes por only at cold start; the ordinary reset leaves the contents alone.
module ohc_nvstore (
  input  wire logic                  clock,     // System clock
  input  wire logic                  por,       // Cold-start clear, high
  input  wire logic                  wr_int,    // Write interval
  input  wire ohc_pkg::ohc_int_min_t int_d,     // New interval
  input  wire logic                  wr_tto,    // Write time-to-go
  input  wire ohc_pkg::ohc_int_min_t tto_d,     // New time-to-go
  input  wire logic                  wr_run,    // Write run time
  input  wire ohc_pkg::ohc_run_min_t run_d,     // New run time
  output ohc_pkg::ohc_int_min_t      int_q,     // Stored interval
  output ohc_pkg::ohc_int_min_t      tto_q,     // Stored time-to-go
  output ohc_pkg::ohc_run_min_t      run_q      // Stored run time
);
  // Interval word
  always_ff @(posedge clock) begin
    if (por) begin
      int_q <= 20'h00000;
    end else if (wr_int) begin
      int_q <= int_d;
    end
  end

  // Time-to-go word
  always_ff @(posedge clock) begin
    if (por) begin
      tto_q <= 20'h00000;
    end else if (wr_tto) begin
      tto_q <= tto_d;
    end
  end

  // Run time word
  always_ff @(posedge clock) begin
    if (por) begin
      run_q <= 23'h000000;
    end else if (wr_run) begin
      run_q <= run_d;
    end
  end
endmodule

// *** core/ohc_counter.sv ***
// Operating hours counter: run time accumulator, service time-to-go and alarm.
// Assumes pins arrive asynchronously and software uses the plain register port.
//
// Overview of operation
// (RULE1) Maint reset edge: clear alarm, reload interval
// (RULE2) Maint reset keeps run hours
// (RULE3) Reset-all edge: alarm off, hours zero, reload
// (RULE4) Monitor high counts both; low holds both
// (RULE5) Alarm when time-to-go reaches zero
// (RULE6) Clear mode: resets, or resets plus monitor low
// (RULE7) Run hours count regardless of maint reset
// (RULE8) Run hours saturate at 99999 hours
// (RULE9) Interval, time-to-go, run hours always retained; rst drops a referenced interval, reloading time-to-go with the software one
// (RULE10) Interval up to 9999 h 59 m
// (RULE11) Run hours offset with minutes up to 59
// (RULE12) Offset without maint reset: interval minus remainder
// (RULE13) No runtime preset; interval change reloads directly
// (RULE14) Interval from referenced block, hours only
// (RULE15) Time-to-go stops at zero
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`include "ohc_cfg.svh"
module ohc_counter #(
  parameter logic [35:0] MINUTE_CYCLES = 36'(`OHC_MINUTE_NS / `OHC_CLK_NS)  // Cycles per minute
) (
  input  wire logic        clock,          // System clock, 100 MHz
  input  wire logic        rst,            // Synchronous reset, high
  input  wire logic        por,            // Cold-start clear of retained words
  input  wire logic        monitor_in,     // Monitoring pin
  input  wire logic        maint_reset,    // Maintenance reset pin
  input  wire logic        reset_all,      // Full reset pin
  input  wire logic [15:0] ref_value,      // Referenced block value in hours
  output logic      [7:0]  ref_block_num,  // Selected block number
  output logic             alarm_out,      // Service alarm
  input  wire logic [7:0]  addr,           // Register byte address
  input  wire logic [31:0] wdata,          // Write data
  input  wire logic        wr,             // Write strobe
  input  wire logic        rd,             // Read strobe
  output logic      [31:0] rdata           // Read data, cycle after rd
);

  // Hours and minutes to minutes, clamped per field and in total
  function automatic ohc_pkg::ohc_run_min_t hm_to_min(input logic [16:0] h, input logic [5:0] m,
                                                       input logic [16:0] hmax);
    logic [16:0] hc;
    logic [5:0]  mc;
    logic [28:0] t;
    hc = (h > hmax) ? hmax : h;
    mc = (m > `OHC_MIN_MAX) ? `OHC_MIN_MAX : m;
    t  = 29'(hc) * 29'(`OHC_MIN_PER_HOUR) + 29'(mc);
    if (t > 29'(`OHC_RUN_MAX_MIN)) begin
      t = 29'(`OHC_RUN_MAX_MIN);
    end
    return t[22:0];
  endfunction

  logic                  mon_lvl;       // Filtered monitor
  logic                  mnt_lvl;       // Filtered maint reset
  logic                  ral_lvl;       // Filtered reset-all
  logic                  mnt_d_r;       // Maint level, last cycle
  logic                  ral_d_r;       // Reset-all level, last cycle
  logic                  mnt_edge;      // Maint rising edge
  logic                  ral_edge;      // Reset-all rising edge
  ohc_pkg::ohc_clr_mode_t mode_r;       // Alarm clear mode
  logic                  src_ref_r;     // Interval from referenced block
  logic                  run_mode_r;    // Runtime (1) or programming (0)
  logic [7:0]            blk_r;         // Block number of reference
  ohc_pkg::ohc_int_min_t local_int_r;   // Interval written by software
  logic                  seen_r;        // A maint reset has happened
  logic [35:0]           pre_r;         // Minute prescaler
  logic                  tick;          // One minute of on-time
  ohc_pkg::ohc_int_min_t eff_int;       // Interval in force
  ohc_pkg::ohc_int_min_t int_q;         // Stored interval
  ohc_pkg::ohc_int_min_t tto_q;         // Stored time-to-go
  ohc_pkg::ohc_run_min_t run_q;         // Stored run time
  logic                  int_chg;       // Interval in force differs
  logic                  off_wr;        // Accepted offset write
  ohc_pkg::ohc_run_min_t off_min;       // Offset in minutes
  ohc_pkg::ohc_int_min_t off_tto;       // Time-to-go after offset
  logic                  wr_tto;        // Time-to-go write enable
  ohc_pkg::ohc_int_min_t tto_nxt;       // Next time-to-go
  logic                  wr_run;        // Run time write enable
  ohc_pkg::ohc_run_min_t run_nxt;       // Next run time
  logic                  clr_cond;      // Alarm clear condition
  logic                  alarm_nxt;     // Next alarm

  // Pin synchronisers
  ohc_sync u_mon (.clock(clock), .rst(rst), .din(monitor_in),  .dout(mon_lvl));
  ohc_sync u_mnt (.clock(clock), .rst(rst), .din(maint_reset), .dout(mnt_lvl));
  ohc_sync u_ral (.clock(clock), .rst(rst), .din(reset_all),   .dout(ral_lvl));

  // Edge history of the reset inputs
  always_ff @(posedge clock) begin
    if (rst) begin
      mnt_d_r <= 1'h0;
      ral_d_r <= 1'h0;
    end else begin
      mnt_d_r <= mnt_lvl;
      ral_d_r <= ral_lvl;
    end
  end
  assign mnt_edge = mnt_lvl & ~mnt_d_r;
  assign ral_edge = ral_lvl & ~ral_d_r;

  // Control register
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_r     <= ohc_pkg::ohc_clr_mode_t'(`OHC_RST_MODE);
      src_ref_r  <= `OHC_RST_SRC;
      run_mode_r <= `OHC_RST_RUN;
      blk_r      <= `OHC_RST_BLK;
    end else if (wr && addr == `OHC_OFS_CTRL) begin
      mode_r     <= ohc_pkg::ohc_clr_mode_t'(wdata[`OHC_CTRL_MODE_BIT]);
      src_ref_r  <= wdata[`OHC_CTRL_SRC_BIT];
      run_mode_r <= wdata[`OHC_CTRL_RUN_BIT];
      blk_r      <= wdata[`OHC_CTRL_BLK_MSB:`OHC_CTRL_BLK_LSB];
    end
  end
  assign ref_block_num = blk_r;

  // Software interval, kept over ordinary reset like the stored words
  always_ff @(posedge clock) begin
    if (por) begin
      local_int_r <= 20'h00000;
    end else if (wr && addr == `OHC_OFS_INTERVAL) begin
      local_int_r <= 20'(hm_to_min(wdata[`OHC_HM_HOUR_MSB:`OHC_HM_HOUR_LSB],  // RULE10
                                   wdata[`OHC_HM_MIN_MSB:`OHC_HM_MIN_LSB], `OHC_INT_HOUR_MAX));
    end
  end

  // Interval in force; a reference counts whole hours, out of range rounds to the limit
  assign eff_int = src_ref_r ? 20'(hm_to_min({1'h0, ref_value}, 6'h00, `OHC_INT_HOUR_MAX))  // RULE14
                             : local_int_r;
  assign int_chg = (eff_int != int_q);

  // Offset preset, ignored while in runtime
  assign off_wr  = wr && addr == `OHC_OFS_OFFSET && !run_mode_r;  // RULE13
  assign off_min = hm_to_min(wdata[`OHC_HM_HOUR_MSB:`OHC_HM_HOUR_LSB],  // RULE11
                             wdata[`OHC_HM_MIN_MSB:`OHC_HM_MIN_LSB], `OHC_RUN_HOUR_MAX);
  assign off_tto = (eff_int == 20'h00000) ? 20'h00000
                 : 20'(23'(eff_int) - (off_min % 23'(eff_int)));  // RULE12

  // Maint reset history for the remainder formula
  always_ff @(posedge clock) begin
    if (por) begin
      seen_r <= 1'h0;
    end else if (mnt_edge) begin
      seen_r <= 1'h1;
    end
  end

  // Minute prescaler runs only on on-time, so partial minutes carry over
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_r <= 36'h000000000;
    end else if (mon_lvl && run_mode_r) begin  // RULE4
      pre_r <= tick ? 36'h000000000 : pre_r + 36'h000000001;
    end
  end
  assign tick = mon_lvl && run_mode_r && (pre_r == MINUTE_CYCLES - 36'h000000001);

  // Next time-to-go: resets, then interval change, then offset, then count down
  always_comb begin
    wr_tto  = 1'h1;
    tto_nxt = tto_q;
    if (ral_edge || mnt_edge) begin
      tto_nxt = eff_int;  // RULE1
    end else if (int_chg) begin
      tto_nxt = eff_int;  // RULE13
    end else if (off_wr && !seen_r) begin
      tto_nxt = off_tto;  // RULE12
    end else if (tick && tto_q != 20'h00000) begin
      tto_nxt = tto_q - 20'h00001;  // RULE4
    end else begin
      wr_tto  = 1'h0;  // RULE15
    end
  end

  // Next run time: reset-all, then offset, then count up; maint reset plays no part
  always_comb begin
    wr_run  = 1'h1;
    run_nxt = run_q;
    if (ral_edge) begin
      run_nxt = 23'h000000;  // RULE3
    end else if (off_wr) begin
      run_nxt = off_min;  // RULE11
    end else if (tick && run_q < `OHC_RUN_MAX_MIN) begin
      run_nxt = run_q + 23'h000001;  // RULE7
    end else begin
      wr_run  = 1'h0;  // RULE8
    end
  end

  // Retained words
  ohc_nvstore u_nv (  // RULE9
    .clock  (clock),
    .por    (por),
    .wr_int (int_chg),
    .int_d  (eff_int),
    .wr_tto (wr_tto),
    .tto_d  (tto_nxt),
    .wr_run (wr_run),
    .run_d  (run_nxt),
    .int_q  (int_q),
    .tto_q  (tto_q),
    .run_q  (run_q)
  );

  // Alarm: clear condition wins, else set while time-to-go is zero
  assign clr_cond  = mnt_lvl || ral_lvl || ral_edge || mnt_edge
                   || (mode_r == ohc_pkg::OHC_CLR_R_EN && !mon_lvl);  // RULE6
  assign alarm_nxt = clr_cond ? 1'h0 : (tto_q == 20'h00000);  // RULE5

  // Alarm register
  always_ff @(posedge clock) begin
    if (rst) begin
      alarm_out <= 1'h0;
    end else begin
      alarm_out <= alarm_nxt;
    end
  end

  // Read data, present only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst || !rd) begin
      rdata <= 32'h00000000;
    end else if (addr == `OHC_OFS_CTRL) begin
      rdata <= {16'h0000, blk_r, 5'h00, run_mode_r, src_ref_r, mode_r};
    end else if (addr == `OHC_OFS_INTERVAL) begin
      rdata <= {12'h000, int_q};
    end else if (addr == `OHC_OFS_STATUS) begin
      rdata <= {29'h00000000, seen_r, mon_lvl, alarm_out};
    end else if (addr == `OHC_OFS_TTG) begin
      rdata <= {12'h000, tto_q};
    end else if (addr == `OHC_OFS_RUNH) begin
      rdata <= {9'h000, run_q};
    end else begin
      rdata <= 32'h00000000;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst || por);

  sequence s_maint_only;
    mnt_edge && !ral_edge;
  endsequence
  sequence s_idle_run;
    !tick && !ral_edge && !off_wr;
  endsequence
  sequence s_offset_write;
    off_wr && !seen_r && !ral_edge && !mnt_edge && !int_chg;
  endsequence
  sequence s_no_load;
    !ral_edge && !mnt_edge && !int_chg && !off_wr;
  endsequence

  chk_maint_reload: assert property (s_maint_only |=> tto_q == $past(eff_int) && !alarm_out)  // RULE1
    else $error("maint reset did not reload time-to-go");
  chk_maint_keep_run: assert property (s_maint_only ##0 s_idle_run |=> run_q == $past(run_q))  // RULE2
    else $error("maint reset changed run time");
  chk_ral_clear: assert property (ral_edge |=> run_q == 23'h000000 && tto_q == $past(eff_int) && !alarm_out)  // RULE3
    else $error("reset-all did not clear");
  chk_run_hold: assert property (s_idle_run |=> run_q == $past(run_q))  // RULE4
    else $error("run time moved without on-time");
  chk_alarm_set: assert property (tto_q == 20'h00000 && !clr_cond |=> alarm_out)  // RULE5
    else $error("alarm not set at zero");
  chk_mon_clear: assert property (mode_r == ohc_pkg::OHC_CLR_R_EN && !mon_lvl |=> !alarm_out)  // RULE6
    else $error("monitor low did not clear alarm");
  chk_run_count: assert property (tick && run_q < `OHC_RUN_MAX_MIN && !ral_edge && !off_wr
                                  |=> run_q == $past(run_q) + 23'h000001)  // RULE7
    else $error("run time did not advance");
  chk_run_sat: assert property (run_q <= `OHC_RUN_MAX_MIN)  // RULE8
    else $error("run time above limit");
  chk_tto_floor: assert property (tick && tto_q == 20'h00000 && !ral_edge && !mnt_edge && !int_chg
                                  && !off_wr |=> tto_q == 20'h00000)  // RULE15
    else $error("time-to-go went below zero");
  chk_int_range: assert property (int_q <= `OHC_INT_MAX_MIN)  // RULE10
    else $error("interval above limit");

  // Presets, interval changes and the referenced interval
  chk_offset_tto: assert property (s_offset_write |=> ((int_q == 20'h00000) ? (tto_q == 20'h00000)  // RULE12
                                   : (23'(tto_q) + run_q % 23'(int_q) == 23'(int_q))))
    else $error("offset preset gave wrong time-to-go");
  chk_seen_set: assert property (mnt_edge |=> seen_r)  // RULE12
    else $error("maint reset not recorded");
  chk_preset_lock: assert property (wr && addr == `OHC_OFS_OFFSET && run_mode_r && !ral_edge && !tick  // RULE13
                                    |=> run_q == $past(run_q))
    else $error("run time preset in runtime");
  chk_int_reload: assert property (int_chg |=> int_q == $past(eff_int) && tto_q == $past(eff_int))  // RULE13
    else $error("interval change did not reload time-to-go");
  chk_ref_hours: assert property (src_ref_r |-> eff_int % 20'(`OHC_MIN_PER_HOUR) == 20'h00000)  // RULE14
    else $error("referenced interval not whole hours");

  // Counting, alarm hold-off and read data
  chk_tto_step: assert property ((tick && tto_q != 20'h00000) ##0 s_no_load  // RULE4
                                 |=> tto_q == $past(tto_q) - 20'h00001)
    else $error("time-to-go did not count down");
  chk_mon_hold: assert property (!mon_lvl |=> pre_r == $past(pre_r))  // RULE4
    else $error("prescaler moved without on-time");
  chk_level_clear: assert property (mnt_lvl || ral_lvl |=> !alarm_out)  // RULE6
    else $error("reset level did not hold alarm off");
  chk_rd_idle: assert property (!rd |=> rdata == 32'h00000000)
    else $error("read data stood without a strobe");
endmodule

// *** dv/ohc_ref_blk.sv ***
// Model of the referenced function block that can supply the service interval.
// Assumes one clock; answers the selected block number one cycle later.
module ohc_ref_blk (
  input  wire logic        clock,          // System clock
  input  wire logic [7:0]  ref_block_num,  // Block selected by the counter
  output logic      [15:0] ref_value       // Actual value, whole hours
);
  timeunit 1ns;
  timeprecision 100ps;

  // Each block reports twice its number as an hours value
  always_ff @(posedge clock) begin
    ref_value <= {7'h00, ref_block_num, 1'b0};
  end
endmodule

// *** dv/ohc_counter_tb.sv ***
// Self-checking bench of the operating hours counter, register port and pins.
// Assumes the minute prescaler is shortened to ten clock cycles.
`include "ohc_cfg.svh"
module ohc_counter_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock;          // System clock
  logic        rst;            // Sync reset
  logic        por;            // Cold-start clear
  logic        monitor_in;     // Monitoring pin
  logic        maint_reset;    // Maintenance reset pin
  logic        reset_all;      // Full reset pin
  logic [15:0] ref_value;      // From the block model
  logic [7:0]  ref_block_num;  // To the block model
  logic        alarm_out;      // Service alarm
  logic [7:0]  addr;           // Register address
  logic [31:0] wdata;          // Write data
  logic        wr;             // Write strobe
  logic        rd;             // Read strobe
  logic [31:0] rdata;          // Read data
  int          err_total;      // Mismatches
  int          compares;       // Comparisons
  int          cyc;            // Cycle count for the hang limit
  logic [31:0] v0;             // Saved reading
  logic [31:0] v1;             // Second reading

  ohc_counter #(.MINUTE_CYCLES(36'h00000000A)) dut (
    .clock(clock), .rst(rst), .por(por), .monitor_in(monitor_in), .maint_reset(maint_reset),
    .reset_all(reset_all), .ref_value(ref_value), .ref_block_num(ref_block_num), .alarm_out(alarm_out),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  ohc_ref_blk blk (.clock(clock), .ref_block_num(ref_block_num), .ref_value(ref_value));

  // Free-running clock, 10 ns period
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Verdict and end of run
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang limit, far above the expected run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  // One-cycle register read, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask

  // Read and compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    chk(d, e);
  endtask

  // Wait for the alarm level, bounded, then compare it
  task automatic alarm_is(input logic v, input int n);
    for (int i = 0; i < n && alarm_out !== v; i++) begin
      @(posedge clock);
    end
    chk({31'h0, alarm_out}, {31'h0, v});
  endtask

  // Pulse one pin for four cycles, then let it settle
  task automatic pin_pulse(input logic sel);
    @(posedge clock);
    if (sel) reset_all <= 1'b1;
    else maint_reset <= 1'b1;
    repeat (4) @(posedge clock);
    reset_all   <= 1'b0;
    maint_reset <= 1'b0;
    repeat (8) @(posedge clock);
  endtask

  // Main sequence
  initial begin
    {rst, por} = 2'h3;
    {monitor_in, maint_reset, reset_all, wr, rd} = 5'h00;
    addr  = 8'h00;
    wdata = 32'h00000000;
    repeat (2) @(posedge clock);
    {rst, por} <= 2'h0;
    // Reset values, empty time-to-go raises the alarm
    rd_chk(`OHC_OFS_CTRL, 32'h00000004);
    rd_chk(`OHC_OFS_TTG, 32'h00000000);
    rd_chk(`OHC_OFS_RUNH, 32'h00000000);
    alarm_is(1'b1, 4);
    rd_chk(8'h20, 32'h00000000);
    wr_reg(`OHC_OFS_TTG, 32'h00000005);
    rd_chk(`OHC_OFS_TTG, 32'h00000000);
    $display("Test reset done");
    // Interval 30 h, then offsets in programming mode
    wr_reg(`OHC_OFS_INTERVAL, 32'h0000001E);
    rd_chk(`OHC_OFS_TTG, 32'h00000708);
    alarm_is(1'b0, 4);
    wr_reg(`OHC_OFS_CTRL, 32'h00000000);
    wr_reg(`OHC_OFS_OFFSET, 32'h00000064);
    rd_chk(`OHC_OFS_RUNH, 32'h00001770);
    rd_chk(`OHC_OFS_TTG, 32'h000004B0);
    wr_reg(`OHC_OFS_OFFSET, 32'h3F000064);
    rd_chk(`OHC_OFS_RUNH, 32'h000017AB);
    rd_chk(`OHC_OFS_TTG, 32'h00000475);
    wr_reg(`OHC_OFS_OFFSET, 32'h3B01869F);
    rd_chk(`OHC_OFS_RUNH, 32'h005B8D44);
    wr_reg(`OHC_OFS_CTRL, 32'h00000004);
    wr_reg(`OHC_OFS_OFFSET, 32'h00000001);
    rd_chk(`OHC_OFS_RUNH, 32'h005B8D44);
    monitor_in <= 1'b1;
    repeat (40) @(posedge clock);
    monitor_in <= 1'b0;
    repeat (10) @(posedge clock);
    rd_chk(`OHC_OFS_RUNH, 32'h005B8D44);
    $display("Test offset done");
    // Short interval, full reset clears run time
    wr_reg(`OHC_OFS_INTERVAL, 32'h03000000);
    rd_chk(`OHC_OFS_INTERVAL, 32'h00000003);
    pin_pulse(1'b1);
    rd_chk(`OHC_OFS_RUNH, 32'h00000000);
    rd_chk(`OHC_OFS_TTG, 32'h00000003);
    // Count down to expiry and beyond
    monitor_in <= 1'b1;
    alarm_is(1'b1, 100);
    rd_chk(`OHC_OFS_RUNH, 32'h00000003);
    rd_chk(`OHC_OFS_TTG, 32'h00000000);
    rd_chk(`OHC_OFS_STATUS, 32'h00000003);
    repeat (25) @(posedge clock);
    monitor_in <= 1'b0;
    repeat (10) @(posedge clock);
    rd_chk(`OHC_OFS_TTG, 32'h00000000);
    rd_reg(`OHC_OFS_RUNH, v0);
    chk(32'(v0 > 32'h00000004), 32'h00000001);
    repeat (30) @(posedge clock);
    rd_reg(`OHC_OFS_RUNH, v1);
    chk(v1, v0);
    alarm_is(1'b1, 1);
    $display("Test count done");
    // Maintenance reset reloads and keeps run time
    pin_pulse(1'b0);
    alarm_is(1'b0, 1);
    rd_chk(`OHC_OFS_TTG, 32'h00000003);
    rd_chk(`OHC_OFS_RUNH, v0);
    rd_chk(`OHC_OFS_STATUS, 32'h00000004);
    // Run time keeps counting with maintenance reset held
    maint_reset <= 1'b1;
    monitor_in  <= 1'b1;
    repeat (40) @(posedge clock);
    monitor_in  <= 1'b0;
    repeat (10) @(posedge clock);
    maint_reset <= 1'b0;
    rd_reg(`OHC_OFS_RUNH, v1);
    chk(32'(v1 > v0 + 32'h00000002), 32'h00000001);
    $display("Test maintenance done");
    // Monitor-low clear mode
    wr_reg(`OHC_OFS_CTRL, 32'h00000005);
    pin_pulse(1'b0);
    monitor_in <= 1'b1;
    alarm_is(1'b1, 100);
    monitor_in <= 1'b0;
    alarm_is(1'b0, 8);
    monitor_in <= 1'b1;
    alarm_is(1'b1, 8);
    monitor_in <= 1'b0;
    wr_reg(`OHC_OFS_CTRL, 32'h00000004);
    repeat (10) @(posedge clock);
    alarm_is(1'b1, 1);
    pin_pulse(1'b1);
    alarm_is(1'b0, 1);
    rd_chk(`OHC_OFS_RUNH, 32'h00000000);
    rd_chk(`OHC_OFS_TTG, 32'h00000003);
    $display("Test clear modes done");
    // Interval clamp and referenced interval
    wr_reg(`OHC_OFS_INTERVAL, 32'h3F002710);
    rd_chk(`OHC_OFS_INTERVAL, 32'h000927BF);
    wr_reg(`OHC_OFS_CTRL, 32'h00000506);
    repeat (5) @(posedge clock);
    chk({24'h0, ref_block_num}, 32'h00000005);
    rd_chk(`OHC_OFS_INTERVAL, 32'h00000258);
    rd_chk(`OHC_OFS_TTG, 32'h00000258);
    $display("Test interval source done");
    final_report();
  end
endmodule
